// *** hdl/alarm_pkg.sv ***
package alarm_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int unsigned NCH      = 12;  // Inputs A, B, C1..C5, D1..D5
	localparam int unsigned CH_A     = 0;   // Input A
	localparam int unsigned CH_B     = 1;   // Input B
	localparam int unsigned CH_C_LO  = 2;   // First of group C
	localparam int unsigned CH_D_LO  = 7;   // First of group D
	localparam int unsigned GRP_N    = 5;   // Channels per scanned group

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] IRQ_STAT_OFS  = 12'h000; // W1C alarm activation events
	localparam logic [11:0] IRQ_MASK_OFS  = 12'h004; // Enable per event bit
	localparam logic [11:0] RELAY1_OFS    = 12'h008; // Relay 1 setup
	localparam logic [11:0] RELAY2_OFS    = 12'h00c; // Relay 2 setup
	localparam logic [11:0] ALM_STATE_OFS = 12'h010; // Low bits 11:0, high bits 27:16
	localparam logic [11:0] MENU_OFS      = 12'h014; // W: commands, R: menu state
	localparam logic [11:0] SHOW_CH_OFS   = 12'h018; // Channel on the display
	localparam logic [3:0]  CH_PAGE       = 4'h1;    // Channel blocks at 0x100 + ch*0x10
	localparam logic [3:0]  CH_CFG_WRD    = 4'h0;    // Word offsets within a block
	localparam logic [3:0]  CH_LO_WRD     = 4'h4;
	localparam logic [3:0]  CH_HI_WRD     = 4'h8;
	localparam logic [3:0]  CH_DB_WRD     = 4'hc;

	// Menu command bits
	localparam int unsigned MENU_RESET_BIT = 0; // Reset key
	localparam int unsigned MENU_OPEN_BIT  = 1; // Alarm key
	localparam int unsigned MENU_YES_BIT   = 2; // Prompt answered yes
	localparam int unsigned MENU_NO_BIT    = 3; // Prompt answered no
	localparam int unsigned MENU_EXIT_BIT  = 4; // Leave setup

	// ------------------------------------------------------------
	// Field layouts and codes
	// ------------------------------------------------------------
	typedef struct packed {
		logic latch; // bit 3
		logic aud;   // bit 2
		logic disp;  // bit 1
		logic en;    // bit 0
	} ch_cfg_t;

	localparam logic [1:0] RLY_OFF   = 2'h0;
	localparam logic [1:0] RLY_ON    = 2'h1;
	localparam logic [1:0] RLY_ALARM = 2'h2;
	localparam logic [1:0] FOL_LOW   = 2'h0;
	localparam logic [1:0] FOL_HIGH  = 2'h1;
	localparam logic [1:0] FOL_BOTH  = 2'h2;

	typedef struct packed {
		logic [1:0] follow; // bits 7:6
		logic [3:0] src;    // bits 5:2
		logic [1:0] mode;   // bits 1:0
	} relay_cfg_t;

	typedef struct packed {
		logic [3:0]  ch;    // Input index
		logic [31:0] value; // Signed, units of 0.0001 K
	} reading_t;

	typedef enum logic [2:0] {
		MENU_IDLE   = 3'h1,
		MENU_PROMPT = 3'h2,
		MENU_SETUP  = 3'h4
	} menu_t;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam ch_cfg_t    CH_CFG_RST = '{latch: 1'b0, aud: 1'b1, disp: 1'b1, en: 1'b0};
	localparam logic [31:0] LO_RST    = 32'h0000_0000; // 0 K
	localparam logic [31:0] HI_RST    = 32'h0098_9680; // 1000 K
	localparam logic [31:0] DB_RST    = 32'h0000_2710; // 1 K
	localparam relay_cfg_t RELAY_RST  = '{follow: 2'h2, src: 4'h0, mode: 2'h0};

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_KHZ       = 125000; // pclk rate
	localparam int unsigned BLINK_HALF_MS = 500;    // Annunciator on/off time
	localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

endpackage : alarm_pkg

// *** hdl/alarm_relay_controller.sv ***
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module alarm_relay_controller #(
	parameter int unsigned BLINK_CYC = alarm_pkg::BLINK_HALF_CYC // Half blink period
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 rd_valid,
	input  wire alarm_pkg::reading_t  rd,
	output logic      [3:0]           annunciator,
	output logic                      show_alarm_msg,
	output logic                      beeper,
	output logic      [1:0]           relay_coil,
	output logic                      prompt_active,
	output logic                      setup_active,
	output logic                      irq
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	alarm_pkg::ch_cfg_t    cfg_q [alarm_pkg::NCH];   // Per-input options
	logic [31:0]           lo_q  [alarm_pkg::NCH];   // Low setpoints
	logic [31:0]           hi_q  [alarm_pkg::NCH];   // High setpoints
	logic [31:0]           db_q  [alarm_pkg::NCH];   // Dead bands
	alarm_pkg::relay_cfg_t rly_q [2];                // Relay setup
	logic [alarm_pkg::NCH-1:0] al_lo_q, al_lo_d;     // Low alarm state
	logic [alarm_pkg::NCH-1:0] al_hi_q, al_hi_d;     // High alarm state
	logic [alarm_pkg::NCH-1:0] stat_q, mask_q;       // Sticky events and mask
	logic [3:0]            show_ch_q;                // Displayed input
	alarm_pkg::menu_t      menu_q;                   // Alarm key dialogue
	logic [31:0]           blink_cnt_q;              // Blink divider
	logic                  blink_q;                  // Blink phase

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic       wr_en;     // Write takes effect this edge
	logic       setup_ph;  // Setup cycle of any transfer
	logic       ch_hit;    // Address inside a channel block
	logic [3:0] ch_idx;    // Channel block index
	logic       glob_hit;  // Address on a global register
	logic [4:0] menu_cmd;  // Menu command pulse bits
	logic       clr_all;   // Clear every latched alarm

	assign ch_idx   = paddr[7:4];
	assign ch_hit   = (paddr[11:8] == alarm_pkg::CH_PAGE) && (ch_idx < 4'(alarm_pkg::NCH))
	                  && (paddr[1:0] == 2'h0);
	assign glob_hit = (paddr == alarm_pkg::IRQ_STAT_OFS) || (paddr == alarm_pkg::IRQ_MASK_OFS)
	                  || (paddr == alarm_pkg::RELAY1_OFS) || (paddr == alarm_pkg::RELAY2_OFS)
	                  || (paddr == alarm_pkg::ALM_STATE_OFS) || (paddr == alarm_pkg::MENU_OFS)
	                  || (paddr == alarm_pkg::SHOW_CH_OFS);
	// Zero wait states keep the slave simple; read data is staged in setup
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !(ch_hit || glob_hit);
	assign setup_ph = psel && !penable;
	assign wr_en    = ce && psel && penable && pwrite && (ch_hit || glob_hit);
	assign menu_cmd = (wr_en && paddr == alarm_pkg::MENU_OFS) ? pwdata[4:0] : 5'h00;

	// Read data staged in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (ce && setup_ph)
		begin
			prdata <= 32'h0000_0000;
			// Channel block words
			if (ch_hit)
			begin
				unique case (paddr[3:0])
					alarm_pkg::CH_CFG_WRD: prdata <= {28'h000_0000, cfg_q[ch_idx]};
					alarm_pkg::CH_LO_WRD:  prdata <= lo_q[ch_idx];
					alarm_pkg::CH_HI_WRD:  prdata <= hi_q[ch_idx];
					default:               prdata <= db_q[ch_idx];
				endcase
			end
			// Global words, unmapped reads as zero
			else if (paddr == alarm_pkg::IRQ_STAT_OFS)
				prdata <= {20'h0_0000, stat_q};
			else if (paddr == alarm_pkg::IRQ_MASK_OFS)
				prdata <= {20'h0_0000, mask_q};
			else if (paddr == alarm_pkg::RELAY1_OFS)
				prdata <= {24'h00_0000, rly_q[0]};
			else if (paddr == alarm_pkg::RELAY2_OFS)
				prdata <= {24'h00_0000, rly_q[1]};
			else if (paddr == alarm_pkg::ALM_STATE_OFS)
				prdata <= {4'h0, al_hi_q, 4'h0, al_lo_q};
			else if (paddr == alarm_pkg::MENU_OFS)
				prdata <= {29'h0000_0000, menu_q};
			else if (paddr == alarm_pkg::SHOW_CH_OFS)
				prdata <= {28'h000_0000, show_ch_q};
		end
	end

	// ------------------------------------------------------------
	// Per-input settings
	// ------------------------------------------------------------
	// Setting writes for all inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// latching off, 1 K dead band
			for (int i = 0; i < alarm_pkg::NCH; i++)
			begin
				cfg_q[i] <= alarm_pkg::CH_CFG_RST;
				lo_q[i]  <= alarm_pkg::LO_RST;
				hi_q[i]  <= alarm_pkg::HI_RST;
				db_q[i]  <= alarm_pkg::DB_RST;
			end
		end
		else if (wr_en && ch_hit)
		begin
			unique case (paddr[3:0])
				alarm_pkg::CH_CFG_WRD: cfg_q[ch_idx] <= alarm_pkg::ch_cfg_t'(pwdata[3:0]);
				alarm_pkg::CH_LO_WRD:  lo_q[ch_idx]  <= pwdata;
				alarm_pkg::CH_HI_WRD:  hi_q[ch_idx]  <= pwdata;
				default:               db_q[ch_idx]  <= pwdata;
			endcase
		end
	end

	// Relay setup and displayed channel
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rly_q[0]  <= alarm_pkg::RELAY_RST;
			rly_q[1]  <= alarm_pkg::RELAY_RST;
			show_ch_q <= 4'h0;
		end
		else if (wr_en)
		begin
			if (paddr == alarm_pkg::RELAY1_OFS)
				rly_q[0] <= alarm_pkg::relay_cfg_t'(pwdata[7:0]);
			if (paddr == alarm_pkg::RELAY2_OFS)
				rly_q[1] <= alarm_pkg::relay_cfg_t'(pwdata[7:0]);
			if (paddr == alarm_pkg::SHOW_CH_OFS)
				show_ch_q <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Alarm key dialogue
	// ------------------------------------------------------------
	logic any_latched; // A latched alarm is holding
	always_comb
	begin
		any_latched = 1'b0;
		for (int i = 0; i < alarm_pkg::NCH; i++)
			any_latched = any_latched | (cfg_q[i].latch & (al_lo_q[i] | al_hi_q[i]));
	end

	// reset key or a yes answer clears latched alarms
	assign clr_all = menu_cmd[alarm_pkg::MENU_RESET_BIT]
	                 || (menu_q == alarm_pkg::MENU_PROMPT && menu_cmd[alarm_pkg::MENU_YES_BIT]);

	// Prompt only when something is latched, otherwise straight to setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			menu_q <= alarm_pkg::MENU_IDLE;
		else if (ce)
		begin
			unique case (menu_q)
				alarm_pkg::MENU_IDLE:
					if (menu_cmd[alarm_pkg::MENU_OPEN_BIT])
						menu_q <= any_latched ? alarm_pkg::MENU_PROMPT : alarm_pkg::MENU_SETUP;
				alarm_pkg::MENU_PROMPT:
					if (menu_cmd[alarm_pkg::MENU_YES_BIT])
						menu_q <= alarm_pkg::MENU_IDLE;
					else if (menu_cmd[alarm_pkg::MENU_NO_BIT])
						menu_q <= alarm_pkg::MENU_SETUP;
				alarm_pkg::MENU_SETUP:
					if (menu_cmd[alarm_pkg::MENU_EXIT_BIT])
						menu_q <= alarm_pkg::MENU_IDLE;
				default:
					menu_q <= alarm_pkg::MENU_IDLE;
			endcase
		end
	end
	assign prompt_active = (menu_q == alarm_pkg::MENU_PROMPT);
	assign setup_active  = (menu_q == alarm_pkg::MENU_SETUP);

	// ------------------------------------------------------------
	// Alarm evaluation, one slice per input
	// ------------------------------------------------------------
	logic signed [31:0] rv; // Reading value, signed
	assign rv = $signed(rd.value);

	for (genvar g = 0; g < alarm_pkg::NCH; g++)
	begin : g_ch
		logic               upd;           // New reading for this input
		logic signed [31:0] hi_rel, lo_rel; // Release thresholds
		logic               hi_base, lo_base;
		logic               hi_new, lo_new;

		// only a reading for this input re-evaluates it
		assign upd     = ce && rd_valid && (rd.ch == 4'(g));
		assign hi_rel  = $signed(hi_q[g]) - $signed(db_q[g]);
		assign lo_rel  = $signed(lo_q[g]) + $signed(db_q[g]);
		assign hi_base = clr_all ? 1'b0 : al_hi_q[g];
		assign lo_base = clr_all ? 1'b0 : al_lo_q[g];

		// above setpoint sets; held until at or below release
		assign hi_new = cfg_q[g].latch ? (hi_base | (rv > $signed(hi_q[g])))
		                : (hi_base ? (rv > hi_rel) : (rv > $signed(hi_q[g])));
		// below setpoint sets; held until at or above release
		assign lo_new = cfg_q[g].latch ? (lo_base | (rv < $signed(lo_q[g])))
		                : (lo_base ? (rv < lo_rel) : (rv < $signed(lo_q[g])));

		// non-latching tracks; latching waits for a clear, a new hit wins
		assign al_hi_d[g] = !cfg_q[g].en ? 1'b0 : (upd ? hi_new : hi_base);
		assign al_lo_d[g] = !cfg_q[g].en ? 1'b0 : (upd ? lo_new : lo_base);

		high_set_a: assert property (@(posedge pclk) disable iff (!presetn)
			upd && cfg_q[g].en && !clr_all && rv > $signed(hi_q[g]) |=> al_hi_q[g])
			else $error("high alarm missed");
		low_set_a: assert property (@(posedge pclk) disable iff (!presetn)
			upd && cfg_q[g].en && !clr_all && rv < $signed(lo_q[g]) |=> al_lo_q[g])
			else $error("low alarm missed");
		high_band_a: assert property (@(posedge pclk) disable iff (!presetn)
			upd && !cfg_q[g].latch && al_hi_q[g] && !clr_all && cfg_q[g].en && rv > hi_rel
			|=> al_hi_q[g])
			else $error("high alarm released inside dead band");
		low_band_a: assert property (@(posedge pclk) disable iff (!presetn)
			upd && !cfg_q[g].latch && al_lo_q[g] && cfg_q[g].en && rv >= lo_rel
			|=> !al_lo_q[g])
			else $error("low alarm kept above release point");
		latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
			cfg_q[g].latch && cfg_q[g].en && al_hi_q[g] && !clr_all && !(wr_en && ch_hit)
			|=> al_hi_q[g])
			else $error("latched alarm dropped without clear");
	end

	// Alarm state and sticky events; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			al_hi_q <= '0;
			al_lo_q <= '0;
			stat_q  <= '0;
			mask_q  <= '0;
		end
		else if (ce)
		begin
			al_hi_q <= al_hi_d;
			al_lo_q <= al_lo_d;
			if (wr_en && paddr == alarm_pkg::IRQ_MASK_OFS)
				mask_q <= pwdata[alarm_pkg::NCH-1:0];
			if (wr_en && paddr == alarm_pkg::IRQ_STAT_OFS)
				stat_q <= (stat_q & ~pwdata[alarm_pkg::NCH-1:0])
				          | ((al_hi_d | al_lo_d) & ~(al_hi_q | al_lo_q));
			else
				stat_q <= stat_q | ((al_hi_d | al_lo_d) & ~(al_hi_q | al_lo_q));
		end
	end
	assign irq = |(stat_q & mask_q);

	clear_yes_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && prompt_active && menu_cmd[alarm_pkg::MENU_YES_BIT] && !rd_valid
		|=> (al_hi_q | al_lo_q) == '0 && menu_q == alarm_pkg::MENU_IDLE)
		else $error("yes answer did not clear alarms");

	// ------------------------------------------------------------
	// Relays
	// ------------------------------------------------------------
	logic [1:0] coil_d; // Coil demand from next alarm state
	for (genvar r = 0; r < 2; r++)
	begin : g_rly
		logic lo_s, hi_s; // Source input alarms, next state
		// A source index past the last input reads as no alarm, never as unknown
		assign lo_s = (rly_q[r].src < 4'(alarm_pkg::NCH)) && al_lo_d[rly_q[r].src];
		assign hi_s = (rly_q[r].src < 4'(alarm_pkg::NCH)) && al_hi_d[rly_q[r].src];
		// off drops, on pulls in; alarm mode follows setting
		assign coil_d[r] = (rly_q[r].mode == alarm_pkg::RLY_ON)
		                   || ((rly_q[r].mode == alarm_pkg::RLY_ALARM)
		                       && (((rly_q[r].follow == alarm_pkg::FOL_LOW)  && lo_s)
		                       ||  ((rly_q[r].follow == alarm_pkg::FOL_HIGH) && hi_s)
		                       ||  ((rly_q[r].follow == alarm_pkg::FOL_BOTH) && (lo_s || hi_s))));

		relay_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
			ce && rly_q[r].mode == alarm_pkg::RLY_OFF && !wr_en |=> !relay_coil[r])
			else $error("relay energized in off mode");
		relay_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
			ce && rly_q[r].mode == alarm_pkg::RLY_ALARM && rly_q[r].follow == alarm_pkg::FOL_HIGH
			&& rly_q[r].src < 4'(alarm_pkg::NCH)
			&& !wr_en |=> relay_coil[r] == al_hi_q[$past(rly_q[r].src)])
			else $error("relay not following high alarm");
	end

	// coil updated on the same edge as the alarm state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			relay_coil <= 2'h0;
		else if (ce)
			relay_coil <= coil_d;
	end

	// ------------------------------------------------------------
	// Front panel
	// ------------------------------------------------------------
	// free-running blink, frozen with the rest by ce
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blink_cnt_q <= 32'h0000_0000;
			blink_q     <= 1'b0;
		end
		else if (ce)
		begin
			if (blink_cnt_q >= BLINK_CYC - 1)
			begin
				blink_cnt_q <= 32'h0000_0000;
				blink_q     <= !blink_q;
			end
			else
				blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
		end
	end

	logic [alarm_pkg::NCH-1:0] vis;   // Active, enabled, displayed
	logic [alarm_pkg::NCH-1:0] sound; // Active, displayed, audible
	for (genvar k = 0; k < alarm_pkg::NCH; k++)
	begin : g_vis
		// dark when off, inactive or not displayed
		assign vis[k]   = cfg_q[k].en && cfg_q[k].disp && (al_hi_q[k] || al_lo_q[k]);
		assign sound[k] = vis[k] && cfg_q[k].aud;
	end

	// Annunciators, beeper and display alternation
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			annunciator    <= 4'h0;
			beeper         <= 1'b0;
			show_alarm_msg <= 1'b0;
		end
		else if (ce)
		begin
			// flash while active; groups C and D are shared
			annunciator[0] <= blink_q && vis[alarm_pkg::CH_A];
			annunciator[1] <= blink_q && vis[alarm_pkg::CH_B];
			annunciator[2] <= blink_q && |vis[alarm_pkg::CH_C_LO +: alarm_pkg::GRP_N];
			annunciator[3] <= blink_q && |vis[alarm_pkg::CH_D_LO +: alarm_pkg::GRP_N];
			beeper <= |sound;
			// shown input alternates message and reading
			show_alarm_msg <= blink_q && (show_ch_q < 4'(alarm_pkg::NCH)) && vis[show_ch_q];
		end
	end

	ann_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !vis[alarm_pkg::CH_A] |=> !annunciator[0])
		else $error("annunciator A lit without visible alarm");
	beep_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && (sound == '0) |=> !beeper)
		else $error("beeper sounding without audible displayed alarm");

endmodule : alarm_relay_controller

`default_nettype wire

// *** test/panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Front panel lamps, message line and relay contacts
// ------------------------------------------------------------
module panel_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clr,            // Forget what was seen so far
	input  wire logic [3:0] annunciator,    // Lamps A, B, C, D
	input  wire logic       show_alarm_msg, // Message line of the display
	input  wire logic [1:0] relay_coil,     // Coil drive per relay
	output logic      [4:0] lit_seen,       // Lamp or message seen on
	output logic      [4:0] dark_seen,      // Lamp or message seen off
	output logic      [1:0] make_closed,    // Make contact per relay
	output logic      [1:0] brk_closed      // Break contact per relay
);
	assign make_closed = relay_coil;
	assign brk_closed  = ~relay_coil;

	// flash capture
	// A lamp that flashes is seen both lit and dark within a window
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lit_seen  <= 5'h00;
			dark_seen <= 5'h00;
		end
		else if (clr)
		begin
			lit_seen  <= 5'h00;
			dark_seen <= 5'h00;
		end
		else
		begin
			lit_seen  <= lit_seen | {show_alarm_msg, annunciator};
			dark_seen <= dark_seen | ~{show_alarm_msg, annunciator};
		end
	end
endmodule : panel_model

`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic                pclk = 1'b0;
	logic                presetn, psel, penable, pwrite, rd_valid, clr;
	logic                ce;  // Clock enable, low freezes the block
	logic                err; // Slave error seen at the access edge
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, q;
	logic                pready, pslverr, show_alarm_msg, beeper;
	logic                prompt_active, setup_active, irq;
	logic [3:0]          annunciator;
	logic [1:0]          relay_coil, make_closed, brk_closed;
	logic [4:0]          lit_seen, dark_seen;
	alarm_pkg::reading_t rd;
	int                  errors = 0;
	int                  n_checks = 0;

	// Short blink so a flash shows within a few cycles
	alarm_relay_controller #(.BLINK_CYC(4)) alarm_relay_controller_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rd_valid(rd_valid), .rd(rd),
		.annunciator(annunciator), .show_alarm_msg(show_alarm_msg), .beeper(beeper),
		.relay_coil(relay_coil), .prompt_active(prompt_active),
		.setup_active(setup_active), .irq(irq));
	panel_model panel_model_inst (
		.pclk(pclk), .presetn(presetn), .clr(clr), .annunciator(annunciator),
		.show_alarm_msg(show_alarm_msg), .relay_coil(relay_coil), .lit_seen(lit_seen),
		.dark_seen(dark_seen), .make_closed(make_closed), .brk_closed(brk_closed));

	// 125 MHz clock
	always #4 pclk = ~pclk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			errors++;
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// A write lands on the access edge; let it settle before outputs are judged
		@(posedge pclk);
		if (n >= 20)
		begin
			errors++;
			close_out();
		end
	endtask : apb

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask : rdc

	// Present one reading, then let the outputs settle
	task automatic send(input logic [3:0] c, input logic [31:0] v);
		@(posedge pclk);
		rd_valid <= 1'b1;
		rd       <= '{ch: c, value: v};
		@(posedge pclk);
		rd_valid <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : send

	// Open a fresh panel window of four blink periods
	task automatic watch();
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (32) @(posedge pclk);
	endtask : watch

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdc(12'h008, 32'h0000_0080);
		rdc(12'h100, 32'h0000_0006);
		rdc(12'h10c, 32'h0000_2710);
		chk(relay_coil, 2'b00);
		rdc(12'h01c, 32'h0000_0000);
		chk(err, 1'b1);
	endtask : t_reset

	// High setpoint 1000, dead band 500 on input A
	task automatic t_thresholds();
		apb(1'b1, 12'h108, 32'h0000_03e8);
		apb(1'b1, 12'h10c, 32'h0000_01f4);
		apb(1'b1, 12'h100, 32'h0000_0007);
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b1, 12'h008, 32'h0000_0082);
		// A reading while the block is frozen must be ignored
		@(posedge pclk);
		ce <= 1'b0;
		send(4'h0, 32'd1001);
		ce <= 1'b1;
		rdc(12'h010, 32'h0000_0000);
		send(4'h0, 32'd1000);
		rdc(12'h010, 32'h0000_0000);
		send(4'h0, 32'd1001);
		rdc(12'h010, 32'h0001_0000);
		chk({irq, relay_coil}, 3'b101);
		send(4'h0, 32'd501);
		rdc(12'h010, 32'h0001_0000);
		send(4'h0, 32'd500);
		rdc(12'h010, 32'h0000_0000);
		chk(relay_coil, 2'b00);
		apb(1'b1, 12'h000, 32'h0000_0001);
		chk(irq, 1'b0);
		send(4'h0, 32'hffff_ffff);
		rdc(12'h010, 32'h0000_0001);
		send(4'h0, 32'd499);
		rdc(12'h010, 32'h0000_0001);
		send(4'h0, 32'd500);
		rdc(12'h010, 32'h0000_0000);
	endtask : t_thresholds

	// Relay 1 follows A low then high; relay 2 forced on and off
	task automatic t_relays();
		apb(1'b1, 12'h008, 32'h0000_0002);
		send(4'h0, 32'd1001);
		chk(relay_coil, 2'b00);
		apb(1'b1, 12'h008, 32'h0000_0042);
		apb(1'b1, 12'h00c, 32'h0000_0001);
		send(4'h0, 32'd1001);
		chk({make_closed, brk_closed}, 4'b1100);
		// Mode code 3 behaves as off
		apb(1'b1, 12'h00c, 32'h0000_0003);
		send(4'h0, 32'd1001);
		chk({make_closed, brk_closed}, 4'b0110);
	endtask : t_relays

	// High alarm on A is still active here
	task automatic t_panel();
		apb(1'b1, 12'h018, 32'h0000_0000);
		watch();
		chk({lit_seen[0], dark_seen[0], beeper}, 3'b111);
		chk({lit_seen[4], dark_seen[4]}, 2'b11);
		apb(1'b1, 12'h100, 32'h0000_0003);
		watch();
		chk({lit_seen[0], beeper}, 2'b10);
		apb(1'b1, 12'h100, 32'h0000_0005);
		watch();
		chk({lit_seen[0], beeper}, 2'b00);
		send(4'h0, 32'd0);
		apb(1'b1, 12'h100, 32'h0000_0007);
	endtask : t_panel

	// One channel of group C, then one of group D
	task automatic t_groups();
		for (int c = 3; c <= 9; c += 6)
		begin
			apb(1'b1, 12'h108 + 12'(c * 16), 32'h0000_03e8);
			apb(1'b1, 12'h100 + 12'(c * 16), 32'h0000_0007);
			send(4'(c), 32'd2000);
			watch();
			chk(lit_seen[3:0], (c < 7) ? 4'b0100 : 4'b1000);
			apb(1'b1, 12'h014, 32'h0000_0001);
			rdc(12'h010, 32'h0000_0000);
		end
	endtask : t_groups

	task automatic t_latch();
		apb(1'b1, 12'h100, 32'h0000_000f);
		send(4'h0, 32'd1001);
		send(4'h0, 32'd0);
		rdc(12'h010, 32'h0001_0000);
		apb(1'b1, 12'h014, 32'h0000_0002);
		chk(prompt_active, 1'b1);
		apb(1'b1, 12'h014, 32'h0000_0004);
		rdc(12'h010, 32'h0000_0000);
		send(4'h0, 32'd1001);
		apb(1'b1, 12'h014, 32'h0000_0002);
		apb(1'b1, 12'h014, 32'h0000_0008);
		chk({setup_active, prompt_active}, 2'b10);
		rdc(12'h010, 32'h0001_0000);
		apb(1'b1, 12'h014, 32'h0000_0010);
		rdc(12'h014, 32'h0000_0001);
	endtask : t_latch

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{presetn, psel, penable, pwrite, rd_valid, clr} = 6'h00;
		ce = 1'b1;
		err = 1'b0;
		{paddr, pwdata} = 44'h0;
		rd = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_thresholds();
		t_relays();
		t_panel();
		t_groups();
		t_latch();
		close_out();
	end
endmodule : tb_top

`default_nettype wire
